// File: design/watchdog_timer.sv
// Watchdog timer with window mode, power-save wake and AXI4-Lite registers
// How it works
// RULE1: Counter runs on low-power RC ticks; oscillator on while watchdog enabled.
// RULE2: Prescaler divides oscillator ticks by 32 or by 128.
// RULE3: At 32 kHz the prescaler period is 1 ms or 4 ms.
// RULE4: Four-bit postscale field, bits 3..0, gives 16 ratios 1:1 to 1:32768.
// RULE5: Reset, clock switch, power-save entry/exit and clear instruction zero counters.
// RULE6: Enabled watchdog keeps counting in sleep and idle.
// RULE7: Time-out in sleep or idle wakes the core instead of resetting.
// RULE8: Software clears the sleep and idle flags itself after wake.
// RULE9: Always-on bit keeps watchdog enabled whatever the soft enable says.
// RULE10: With always-on clear, soft enable bit 5 turns the watchdog on or off.
// RULE11: Every device reset clears the soft enable bit.
// RULE12: In window mode software clears only in the last quarter of the period.
// RULE13: Window mode: a clear before the last quarter causes a watchdog reset.
// RULE14: Time-out sets the sticky flag at bit 4; software clears it.
// RULE15: Prescale select 1 means divide by 128, 0 means divide by 32.
// RULE16: Window disable 1 means non-window, 0 means window mode.
// RULE17: Always-on keeps the oscillator running; clearing soft enable has no effect.
// RULE18: Postscale code 1111 is 1:32768, 1110 is 1:16384, halving per step.
// RULE19: Time-out in normal run raises device reset and sets the flag.
// RULE20: Postscaler counts prescaler periods; time-out after the ratio elapses.
module watchdog_timer #(
  parameter int LprcDiv = watchdog_pkg::LOW_POWER_RC_OSCILLATOR_DIV
) (
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  input  wire logic                            deviceReset,
  input  wire logic                            clearWatchdogInstr,
  input  wire logic                            powerSaveInstr,
  input  wire logic                            powerSaveIdle,
  input  wire logic                            powerSaveExit,
  input  wire logic                            clockSwitchDone,
  output logic                                 watchdogReset,
  output logic                                 wakeUp,
  output logic                                 lowPowerRcOn,
  output logic                                 powerSaved,
  input  wire logic [watchdog_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output logic                                 wready,
  output logic [1:0]                           bresp,
  output logic                                 bvalid,
  input  wire logic                            bready,
  input  wire logic [watchdog_pkg::ADDR_W-1:0] araddr,
  input  wire logic                            arvalid,
  output logic                                 arready,
  output logic [31:0]                          rdata,
  output logic [1:0]                           rresp,
  output logic                                 rvalid,
  input  wire logic                            rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Last prescaler count for the selected ratio
  function automatic logic [watchdog_pkg::PRE_W-1:0] preTop(input logic sel);
    preTop = sel ? watchdog_pkg::PRE_TOP_128 : watchdog_pkg::PRE_TOP_32; // RULE2 RULE15
  endfunction

  // Postscale ratio is two to the power of the code
  function automatic logic [watchdog_pkg::POST_W-1:0] postRatio(input logic [3:0] code);
    postRatio = watchdog_pkg::POST_W'(1) << code; // RULE4 RULE18
  endfunction

  // Oscillator ticks since the last clear, and ticks in a full period
  function automatic logic [watchdog_pkg::TICK_W-1:0] ticks(
    input logic                            sel,
    input logic [watchdog_pkg::POST_W-1:0] post,
    input logic [watchdog_pkg::PRE_W-1:0]  pre
  );
    logic [watchdog_pkg::TICK_W-1:0] wide;
    wide  = watchdog_pkg::TICK_W'(post);
    ticks = (sel ? wide << watchdog_pkg::PRE_SHIFT_128 : wide << watchdog_pkg::PRE_SHIFT_32)
            + watchdog_pkg::TICK_W'(pre);
  endfunction

  function automatic logic [31:0] regRead(
    input watchdog_pkg::state_type st,
    input logic [watchdog_pkg::ADDR_W-1:0] addr
  );
    logic [31:0] v;
    v = '0;
    if (addr == watchdog_pkg::CONFIG_OFS) begin
      v[watchdog_pkg::POST_MSB:watchdog_pkg::POST_LSB] = st.cfg.postscaleSelect;
      v[watchdog_pkg::PRE_BIT]    = st.cfg.prescaleSelect;
      v[watchdog_pkg::WINDOW_DISABLE_BIT] = st.cfg.windowDisable;
      v[watchdog_pkg::ALWAYS_BIT] = st.cfg.alwaysOnSelect;
    end else if (addr == watchdog_pkg::CONTROL_OFS) begin
      v[watchdog_pkg::IDLE_BIT]   = st.idleFlag;
      v[watchdog_pkg::SLEEP_BIT]  = st.sleepFlag;
      v[watchdog_pkg::TO_BIT]     = st.timeoutFlag;
      v[watchdog_pkg::SOFTEN_BIT] = st.softEnable;
    end else if (addr == watchdog_pkg::COUNT_OFS) begin
      v[watchdog_pkg::CNT_PRE_LSB +: watchdog_pkg::PRE_W]   = st.preCnt;
      v[watchdog_pkg::CNT_POST_LSB +: watchdog_pkg::POST_W] = st.postCnt;
    end
    regRead = v;
  endfunction

  function automatic logic addrMapped(input logic [watchdog_pkg::ADDR_W-1:0] addr);
    addrMapped = (addr == watchdog_pkg::CONFIG_OFS) || (addr == watchdog_pkg::CONTROL_OFS)
                 || (addr == watchdog_pkg::COUNT_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  localparam logic [watchdog_pkg::DIV_W-1:0] DivLast = watchdog_pkg::DIV_W'(LprcDiv - 1);

  watchdog_pkg::state_type s;
  watchdog_pkg::state_type n;

  logic                              enabled;
  logic                              lprcTick;
  logic                              preLast;
  logic                              postLast;
  logic                              windowOpen;
  logic                              timeout;
  logic                              earlyClear;
  logic                              anyReset;
  logic                              clearCnt;
  logic                              enterSave;
  logic                              leaveSave;
  logic [watchdog_pkg::TICK_W-1:0]   elapsed;
  logic [watchdog_pkg::TICK_W-1:0]   period;

  always_comb begin
    n = s;
    n.wdtReset = 1'b0;
    n.wake     = 1'b0;

    // Own watchdog reset counts as a device reset one cycle later
    anyReset = deviceReset | s.wdtReset;

    enabled  = s.cfg.alwaysOnSelect | s.softEnable; // RULE9 RULE10 RULE17
    lprcTick = s.lprcOn && (s.divCnt == DivLast); // RULE1
    preLast  = s.preCnt == preTop(s.cfg.prescaleSelect);
    postLast = s.postCnt == postRatio(s.cfg.postscaleSelect) - watchdog_pkg::POST_W'(1);

    // Window opens once three quarters of the period have passed
    elapsed    = ticks(s.cfg.prescaleSelect, s.postCnt, s.preCnt);
    period     = ticks(s.cfg.prescaleSelect, postRatio(s.cfg.postscaleSelect), '0);
    windowOpen = elapsed >= (period - (period >> 2)); // RULE12 RULE13

    timeout    = enabled && lprcTick && preLast && postLast; // RULE20
    earlyClear = enabled && clearWatchdogInstr && !s.powerSaved
                 && !s.cfg.windowDisable && !windowOpen; // RULE13 RULE16
    enterSave  = powerSaveInstr && !s.powerSaved;
    leaveSave  = s.powerSaved && (powerSaveExit || timeout);

    clearCnt = anyReset || clockSwitchDone || enterSave || leaveSave
               || (clearWatchdogInstr && !s.powerSaved) || !enabled; // RULE5

    //////////////////////////////////////////////////////////////////////////
    // Oscillator and counters

    n.lprcOn = enabled; // RULE1 RULE17
    // Oscillator ticks are modelled from the core clock, one every LprcDiv cycles, with a free-running phase
    if (!s.lprcOn || lprcTick) begin
      n.divCnt = '0;
    end else begin
      n.divCnt = s.divCnt + watchdog_pkg::DIV_W'(1);
    end

    if (clearCnt || (lprcTick && preLast && postLast)) begin
      n.preCnt  = '0;
      n.postCnt = '0;
    end else if (lprcTick) begin
      if (preLast) begin
        n.preCnt  = '0;
        n.postCnt = s.postCnt + watchdog_pkg::POST_W'(1); // RULE20
      end else begin
        n.preCnt = s.preCnt + watchdog_pkg::PRE_W'(1); // RULE2 RULE3
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Time-out, wake and power save

    if (timeout && s.powerSaved) begin
      n.wake = 1'b1; // RULE6 RULE7
    end else if ((timeout || earlyClear) && !anyReset) begin
      n.wdtReset = 1'b1; // RULE13 RULE19
    end

    if (anyReset) begin
      n.powerSaved = 1'b0;
    end else if (enterSave) begin
      n.powerSaved = 1'b1;
    end else if (leaveSave) begin
      n.powerSaved = 1'b0; // RULE7
    end

    //////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write

    if (s.awRdy && awvalid) begin
      n.awAddr = awaddr;
      n.awRdy  = 1'b0;
    end
    if (s.wRdy && wvalid) begin
      n.wData  = wdata;
      n.wStrb0 = wstrb[0];
      n.wRdy   = 1'b0;
    end
    if (!s.awRdy && !s.wRdy && !s.bVld) begin
      n.bVld  = 1'b1;
      n.bResp = addrMapped(s.awAddr) ? watchdog_pkg::RESP_OKAY : watchdog_pkg::RESP_SLVERR;
      // Every writable field sits in byte lane 0
      if (s.wStrb0) begin
        if (s.awAddr == watchdog_pkg::CONFIG_OFS) begin
          n.cfg.postscaleSelect = s.wData[watchdog_pkg::POST_MSB:watchdog_pkg::POST_LSB];
          n.cfg.prescaleSelect  = s.wData[watchdog_pkg::PRE_BIT];
          n.cfg.windowDisable   = s.wData[watchdog_pkg::WINDOW_DISABLE_BIT];
          n.cfg.alwaysOnSelect  = s.wData[watchdog_pkg::ALWAYS_BIT];
        end else if (s.awAddr == watchdog_pkg::CONTROL_OFS) begin
          n.softEnable  = s.wData[watchdog_pkg::SOFTEN_BIT]; // RULE10
          n.timeoutFlag = s.wData[watchdog_pkg::TO_BIT]; // RULE14
          n.sleepFlag   = s.wData[watchdog_pkg::SLEEP_BIT]; // RULE8
          n.idleFlag    = s.wData[watchdog_pkg::IDLE_BIT]; // RULE8
        end
      end
    end
    if (s.bVld && bready) begin
      n.bVld  = 1'b0;
      n.awRdy = 1'b1;
      n.wRdy  = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // Hardware sets after software writes, so a set in the clearing cycle wins

    if (timeout || earlyClear) begin
      n.timeoutFlag = 1'b1; // RULE14 RULE19
    end
    if (enterSave) begin
      n.idleFlag  = s.idleFlag | powerSaveIdle;
      n.sleepFlag = s.sleepFlag | !powerSaveIdle;
    end
    if (anyReset) begin
      n.softEnable = 1'b0; // RULE11
    end

    //////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read

    if (s.arRdy && arvalid) begin
      n.arRdy = 1'b0;
      n.rVld  = 1'b1;
      n.rData = regRead(s, araddr);
      n.rResp = addrMapped(araddr) ? watchdog_pkg::RESP_OKAY : watchdog_pkg::RESP_SLVERR;
    end
    if (s.rVld && rready) begin
      n.rVld  = 1'b0;
      n.arRdy = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s                 <= '0;
      // Field by field: the carrier is narrower than the byte-wide reset word
      s.cfg.postscaleSelect <= watchdog_pkg::CONFIG_RESET[watchdog_pkg::POST_MSB:watchdog_pkg::POST_LSB];
      s.cfg.prescaleSelect  <= watchdog_pkg::CONFIG_RESET[watchdog_pkg::PRE_BIT];
      s.cfg.windowDisable   <= watchdog_pkg::CONFIG_RESET[watchdog_pkg::WINDOW_DISABLE_BIT];
      s.cfg.alwaysOnSelect  <= watchdog_pkg::CONFIG_RESET[watchdog_pkg::ALWAYS_BIT];
      s.awRdy           <= 1'b1;
      s.wRdy            <= 1'b1;
      s.arRdy           <= 1'b1;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop

  assign watchdogReset = s.wdtReset;
  assign wakeUp        = s.wake;
  assign lowPowerRcOn  = s.lprcOn;
  assign powerSaved    = s.powerSaved;
  assign awready       = s.awRdy;
  assign wready        = s.wRdy;
  assign bvalid        = s.bVld;
  assign bresp         = s.bResp;
  assign arready       = s.arRdy;
  assign rvalid        = s.rVld;
  assign rdata         = s.rData;
  assign rresp         = s.rResp;

endmodule

// File: design/watchdog_pkg.sv
// Constants and carrier types for the watchdog timer block
package watchdog_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and oscillator timing
  localparam int CLK_HZ  = 250_000_000;
  localparam int LOW_POWER_RC_OSCILLATOR_HZ = 32_000;
  // Core clocks per low-power RC oscillator period
  localparam int LOW_POWER_RC_OSCILLATOR_DIV = CLK_HZ / LOW_POWER_RC_OSCILLATOR_HZ;
  localparam int DIV_W    = 13;
  localparam int PRE_W    = 7;
  localparam int POST_W   = 16;
  localparam int TICK_W   = 24;

  // Prescaler ratios
  localparam logic [PRE_W-1:0] PRE_TOP_32  = 7'h1F;
  localparam logic [PRE_W-1:0] PRE_TOP_128 = 7'h7F;
  localparam int PRE_SHIFT_32  = 5;
  localparam int PRE_SHIFT_128 = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CONFIG_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] CONTROL_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] COUNT_OFS   = 8'h08;

  // Configuration register fields
  localparam int POST_LSB   = 0;
  localparam int POST_MSB   = 3;
  localparam int PRE_BIT    = 4;
  localparam int WINDOW_DISABLE_BIT = 6;
  localparam int ALWAYS_BIT = 7;
  // Non-window, divide by 128, longest postscale, always-on off
  localparam logic [7:0] CONFIG_RESET = 8'h5F;

  // Reset-control register fields
  localparam int IDLE_BIT   = 2;
  localparam int SLEEP_BIT  = 3;
  localparam int TO_BIT     = 4;
  localparam int SOFTEN_BIT = 5;

  // Count register fields
  localparam int CNT_PRE_LSB  = 0;
  localparam int CNT_POST_LSB = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic       alwaysOnSelect;
    logic       windowDisable;
    logic       prescaleSelect;
    logic [3:0] postscaleSelect;
  } cfg_type;

  typedef struct packed {
    cfg_type           cfg;
    logic              softEnable;
    logic              timeoutFlag;
    logic              sleepFlag;
    logic              idleFlag;
    logic              powerSaved;
    logic              lprcOn;
    logic [DIV_W-1:0]  divCnt;
    logic [PRE_W-1:0]  preCnt;
    logic [POST_W-1:0] postCnt;
    logic              wdtReset;
    logic              wake;
    logic              awRdy;
    logic              wRdy;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0]       wData;
    logic              wStrb0;
    logic              bVld;
    logic [1:0]        bResp;
    logic              arRdy;
    logic              rVld;
    logic [1:0]        rResp;
    logic [31:0]       rData;
  } state_type;

endpackage

// File: bench/watchdog_timer_props.sv
// Port-level assertions for the watchdog timer, bound to its top module
module watchdog_timer_props #(
  parameter int LprcDiv = 4
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        deviceReset,
  input wire logic        clearWatchdogInstr,
  input wire logic        powerSaveInstr,
  input wire logic        powerSaveExit,
  input wire logic        clockSwitchDone,
  input wire logic        watchdogReset,
  input wire logic        wakeUp,
  input wire logic        lowPowerRcOn,
  input wire logic        powerSaved,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // One tick of slack: the divider phase is not cleared with the counters
  localparam int MinQuiet = LprcDiv * 31;
  logic [15:0] quiet_q;
  logic [15:0] quiet_d;
  ////////////////////////////////////////
  always_comb begin
    quiet_d = (quiet_q == 16'hFFFF) ? quiet_q : quiet_q + 16'h1;
    if (clearWatchdogInstr || powerSaveInstr || powerSaveExit || clockSwitchDone || deviceReset) quiet_d = 16'h0;
    if (watchdogReset || wakeUp || !lowPowerRcOn) quiet_d = 16'h0;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) quiet_q <= 16'h0;
    else quiet_q <= quiet_d;
  end
  ////////////////////////////////////////
  sequence wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rdTaken;
    arvalid && arready;
  endsequence
  wr_answer_a: assert property (wrTaken |-> ##[1:2] bvalid) else $error("write response missing");
  rd_answer_a: assert property (rdTaken |=> rvalid) else $error("read data missing");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
  wake_in_save_a: assert property (wakeUp |-> $past(powerSaved))
    else $error("wake outside power save");
  reset_awake_a: assert property (watchdogReset |-> !$past(powerSaved))
    else $error("reset raised in power save");
  reset_pulse_a: assert property (watchdogReset |=> !watchdogReset)
    else $error("reset pulse too long");
  osc_on_reset_a: assert property (watchdogReset |-> $past(lowPowerRcOn))
    else $error("reset with oscillator off");
  min_period_a: assert property (watchdogReset |-> quiet_q >= MinQuiet || $past(clearWatchdogInstr))
    else $error("time-out too early");
  exit_save_a: assert property (powerSaveExit && powerSaved |=> !powerSaved)
    else $error("power save not left");
endmodule
bind watchdog_timer watchdog_timer_props #(.LprcDiv(LprcDiv)) i_watchdog_timer_props (.clk, .rst_b, .deviceReset,
  .clearWatchdogInstr, .powerSaveInstr, .powerSaveExit, .clockSwitchDone, .watchdogReset, .wakeUp, .lowPowerRcOn,
  .powerSaved, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid,
  .rready);

// File: bench/cpu_stub.sv
// Processor core stand-in issuing watchdog-related instruction pulses
module cpu_stub (
  input  wire logic clk,
  input  wire logic powerSaved,
  output logic      clearWatchdogInstr,
  output logic      powerSaveInstr,
  output logic      powerSaveIdle,
  output logic      powerSaveExit,
  output logic      clockSwitchDone,
  output logic      deviceReset
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {clearWatchdogInstr, powerSaveInstr, powerSaveIdle, powerSaveExit, clockSwitchDone, deviceReset} = 6'h0;
  // Code 0 clear, 1 sleep, 2 idle, 3 exit, 4 clock switch, 5 device reset; dly makes the core slow
  task automatic issue(input logic [2:0] code, input int dly);
    repeat (dly) @(posedge clk);
    @(posedge clk);
    // A sleeping core executes nothing, so no clear leaves it then
    clearWatchdogInstr <= (code == 3'h0) && !powerSaved;
    powerSaveInstr <= (code == 3'h1) || (code == 3'h2);
    powerSaveIdle <= (code == 3'h2);
    powerSaveExit <= (code == 3'h3);
    clockSwitchDone <= (code == 3'h4);
    deviceReset <= (code == 3'h5);
    @(posedge clk);
    {clearWatchdogInstr, powerSaveInstr, powerSaveExit, clockSwitchDone, deviceReset} <= 5'h0;
  endtask
endmodule

// File: bench/watchdog_timer_tb.sv
// Self-checking bench for the watchdog timer
module watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Div = 4;
  localparam logic [7:0] CFG = watchdog_pkg::CONFIG_OFS;
  localparam logic [7:0] CTL = watchdog_pkg::CONTROL_OFS;
  logic        clk = 1'h0, rst_b = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        deviceReset, clearWatchdogInstr, powerSaveInstr, powerSaveIdle, powerSaveExit, clockSwitchDone;
  logic        watchdogReset, wakeUp, lowPowerRcOn, powerSaved, awready, wready, bvalid, arready, rvalid, p;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [65:0] e;
  int          miscompares = 0, numChecks = 0, seed = 52, cyc = 0, q;
  logic [1:0]  bQ[$];
  logic [65:0] rdQ[$];
  int          evQ[$];
  watchdog_timer #(.LprcDiv(Div)) i_watchdog_timer (.clk, .rst_b, .deviceReset, .clearWatchdogInstr, .powerSaveInstr,
    .powerSaveIdle, .powerSaveExit, .clockSwitchDone, .watchdogReset, .wakeUp, .lowPowerRcOn, .powerSaved, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);
  cpu_stub i_cpu_stub (.clk, .powerSaved, .clearWatchdogInstr, .powerSaveInstr, .powerSaveIdle, .powerSaveExit,
    .clockSwitchDone, .deviceReset);
  initial forever #2 clk = ~clk;
  ////////////////////////////////////////
  task automatic wrapUp(input bit hung);
    if (hung) miscompares++;
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chkVal(input logic [33:0] got, input logic [33:0] exp);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Events carry cycle*2+kind; the divider phase costs a few cycles of slack
  task automatic chkEv(input logic kind, input int n);
    numChecks++;
    if (kind !== 1'(n % 2) || cyc - n / 2 < -2 || cyc - n / 2 > 8) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, {kind, cyc}, n);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (bvalid && bready) chkVal(34'(bresp), 34'(bQ.pop_front()));
    if (rvalid && rready) begin
      e = rdQ.pop_front();
      chkVal({rresp, rdata & e[63:32]}, {e[65:64], e[31:0]});
    end
    if (watchdogReset || wakeUp) chkEv(wakeUp, (evQ.size() > 0) ? evQ.pop_front() : -999);
  end
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n = 0;
    bQ.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid && n < 300);
    bready <= 1'h0;
    if (n >= 300) wrapUp(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFF_FFFF,
                    input logic [1:0] r = 2'h0);
    int n = 0;
    rdQ.push_back({r, m, x});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'h0;
    end while (!rvalid && n < 300);
    rready <= 1'h0;
    if (n >= 300) wrapUp(1);
  endtask
  function automatic int per(input logic pre, input int post);
    return Div * (pre ? 128 : 32) * (1 << post);
  endfunction
  task automatic note(input int kind, input int dt);
    evQ.push_back((cyc + dt) * 2 + kind);
  endtask
  task automatic drain(input int lim);
    repeat (lim) if (evQ.size() > 0) @(posedge clk);
    if (evQ.size() > 0) wrapUp(1);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    rd(CFG, 32'h5F);
    rd(CTL, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0, 32'hFFFF_FFFF, 2'h2);
    wr(8'h0C, 32'h1, 2'h2);
    for (int i = 0; i < 4; i++) begin
      p = 1'($random(seed));
      q = $random(seed) & 3;
      wr(CFG, {25'h0, 1'h1, 1'h0, p, 4'(q)});
      wr(CTL, 32'h20);
      // Oscillator flag follows the enable one edge late
      @(negedge clk);
      chkVal(34'(lowPowerRcOn), 34'h1);
      i_cpu_stub.issue(3'h0, 0);
      note(0, per(p, q));
      drain(per(p, q) + 50);
      rd(CTL, 32'h10);
      wr(CTL, 32'h0);
    end
    wr(CTL, 32'h20);
    i_cpu_stub.issue(3'h5, 0);
    rd(CTL, 32'h0);
    chkVal(34'(lowPowerRcOn), 34'h0);
    wr(CFG, 32'hC0);
    wr(CTL, 32'h0);
    chkVal(34'(lowPowerRcOn), 34'h1);
    i_cpu_stub.issue(3'h0, 0);
    note(0, per(0, 0));
    drain(200);
    wr(CFG, 32'h40);
    wr(CTL, 32'h20);
    i_cpu_stub.issue(3'h0, 0);
    i_cpu_stub.issue(3'h4, 60);
    note(0, per(0, 0));
    drain(300);
    wr(CFG, 32'h02);
    wr(CTL, 32'h20);
    i_cpu_stub.issue(3'h0, 100);
    note(0, 0);
    drain(50);
    rd(CTL, 32'h10, 32'h30);
    wr(CTL, 32'h20);
    i_cpu_stub.issue(3'h0, 440);
    note(0, per(0, 2));
    drain(700);
    wr(CFG, 32'h40);
    for (int k = 1; k < 3; k++) begin
      wr(CTL, 32'h20);
      i_cpu_stub.issue(3'(k), 20);
      @(negedge clk);
      chkVal(34'(powerSaved), 34'h1);
      note(1, per(0, 0));
      drain(300);
      rd(CTL, 32'h10 >> k, 32'hC);
      wr(CTL, 32'h0);
    end
    wr(CTL, 32'h20);
    i_cpu_stub.issue(3'h1, 0);
    i_cpu_stub.issue(3'h3, 60);
    note(0, per(0, 0));
    drain(300);
    wrapUp(0);
  end
endmodule
